// ---- cps_core_state.sv ----
// Program counter, return stack, operand pointer and skip sequencing
// What this block does
// - Sequencing serves the 68-instruction set
// - Four return slots, four nesting levels
// - Table lookup and interrupt each use a slot
// - Slots 11 bits, level pointer 2 bits
// - PC: 4-bit page, 7-bit in-page, separate loads
// - Operand pointer is high index over low
// - Memory operands use the pointed RAM word
// - Aux registers not initialised by reset
// - After back-up, index and aux undefined
// - Skip voids next instruction, no PC+2
// - Skipped table call or returns take 1 cycle
// - Reset starts at page 0 address 0
// - Back-up entry sets level pointer to 3
`timescale 1ns/1ps
module cps_core_state #(
  parameter int LAST_PAGE = 15
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire cps_pkg::cps_instr_t          instr,
  input  wire logic                         int_entry,
  output cps_pkg::cps_pc_t                  pc,
  output logic [cps_pkg::LVL_W-1:0]         return_level_pointer,
  output logic [cps_pkg::DPTR_W-1:0]        operand_ram_pointer,
  output logic                              ram_wr_en,
  output logic [cps_pkg::AUX3_W-1:0]        aux_three_bit_reg,
  output logic [cps_pkg::AUX8_W-1:0]        aux_eight_bit_reg,
  output logic                              skip_pending,
  output logic                              busy,
  output logic [1:0]                        instr_cycles
);
  import cps_pkg::*;

  // Refuse a page limit the 4-bit page field cannot reach
  if (LAST_PAGE < 0 || LAST_PAGE > 15) begin : g_bad_last_page
    $error("cps_core_state: LAST_PAGE out of range");
  end
  // Pointer and counter fields must tile their carriers exactly
  if (PAGE_W + INPAGE_W != PC_W || XIDX_W + YIDX_W != DPTR_W) begin : g_bad_split
    $error("cps_core_state: field split does not match carrier width");
  end

  cps_pc_t                  pc_r, pc_nxt;
  logic [LVL_W-1:0]         lvl_r, lvl_nxt;
  logic                     skip_r, skip_nxt;
  logic [XIDX_W-1:0]        x_r, x_nxt;
  logic [YIDX_W-1:0]        y_r, y_nxt;
  logic [AUX3_W-1:0]        aux3_r, aux3_nxt;
  logic [AUX8_W-1:0]        aux8_r, aux8_nxt;
  logic                     wr_r, wr_nxt;
  logic [1:0]               cnt_r, cnt_nxt;
  logic [1:0]               cyc_r, cyc_nxt;
  logic                     push;
  logic [LVL_W-1:0]         push_idx;
  logic [PC_W-1:0]          pop_addr;
  logic                     busy_r, busy_nxt;
  cps_pc_t                  pc_nxt_ret;
  logic                     act;
  logic                     last_cycle;

  // Sequential fetch steps within the page; only branches change the page
  function automatic cps_pc_t pc_inc(input cps_pc_t p);
    cps_pc_t q;
    q = p;
    q.inpage = p.inpage + 7'h01;
    return q;
  endfunction

  function automatic logic takes_slot(input cps_flow_t f);
    return (f == CPS_OP_CALL) || (f == CPS_OP_TABLE_CALL);
  endfunction

  function automatic logic is_return(input cps_flow_t f);
    return (f == CPS_OP_RETURN) || (f == CPS_OP_RETURN_SKIP);
  endfunction

  // Slot at level+1 takes the address after the call
  cps_return_stack #(
    .DEPTH (SLOT_CNT),
    .WIDTH (PC_W)
  ) u_stack (
    .clk     (clk),
    .wr_en   (push),
    .wr_idx  (push_idx),
    .wr_data ({pc_nxt_ret.page, pc_nxt_ret.inpage}),
    .rd_idx  (lvl_r),
    .rd_data (pop_addr)
  );

  // Push and timing decode shared by both state groups
  always_comb begin
    pc_nxt_ret = pc_inc(pc_r);
    last_cycle = (cnt_r == 2'h0);
    act        = instr.valid && last_cycle;
    // Stack push for calls, table lookup and interrupt entry
    // A voided call leaves the stack untouched
    push     = act && !skip_r && (takes_slot(instr.flow) || int_entry);
    push_idx = lvl_r + 2'h1;
  end

  // Control state: PC, level pointer, skip and cycle count
  always_comb begin
    pc_nxt   = pc_r;
    lvl_nxt  = lvl_r;
    skip_nxt = skip_r;
    wr_nxt   = 1'b0;
    cnt_nxt  = cnt_r;
    cyc_nxt  = cyc_r;
    // Later cycles of a long instruction only count down
    if (instr.valid && !last_cycle) begin
      cnt_nxt = cnt_r - 2'h1;
    end else if (act) begin
      pc_nxt = pc_inc(pc_r);
      if (skip_r) begin
        // Voided instruction: fetched, PC steps by one only
        skip_nxt = 1'b0;
        if (instr.flow == CPS_OP_TABLE_CALL || is_return(instr.flow)) begin
          cyc_nxt = CYC_SKIP_SHORT;
        end else begin
          cyc_nxt = instr.cycles;
        end
      end else begin
        cyc_nxt  = instr.cycles;
        skip_nxt = instr.skip_cond;
        wr_nxt   = instr.ram_wr;
        // Interrupt entry rides on the taken instruction and shares its push
        if (takes_slot(instr.flow) || int_entry) begin
          lvl_nxt = lvl_r + 2'h1;
        end
        if (is_return(instr.flow)) begin
          pc_nxt   = pop_addr;
          lvl_nxt  = lvl_r - 2'h1;
          skip_nxt = instr.skip_cond || (instr.flow == CPS_OP_RETURN_SKIP);
        end
        if (instr.load_page) begin
          pc_nxt.page = instr.page;
        end
        if (instr.load_inpage) begin
          pc_nxt.inpage = instr.inpage;
        end
        if (instr.backup) begin
          // Back-up entry: level pointer forced, pending skip dropped
          lvl_nxt  = LVL_BACKUP;
          skip_nxt = 1'b0;
          pc_nxt.page   = PC_PAGE_RST;
          pc_nxt.inpage = PC_INPAGE_RST;
        end
      end
      if (instr.cycles > 2'h1 && !(skip_r && cyc_nxt == CYC_SKIP_SHORT)) begin
        cnt_nxt = cyc_nxt - 2'h1;
      end
    end
    // Busy registered so the port comes straight from a flop
    busy_nxt = (cnt_nxt != 2'h0);
  end

  // Index and aux loads, voided like every other side effect
  always_comb begin
    x_nxt    = x_r;
    y_nxt    = y_r;
    aux3_nxt = aux3_r;
    aux8_nxt = aux8_r;
    if (act && !skip_r) begin
      if (instr.load_x) begin
        x_nxt = instr.x_val;
      end
      if (instr.load_y) begin
        y_nxt = instr.y_val;
      end
      if (instr.load_aux3) begin
        aux3_nxt = instr.aux3_val;
      end
      if (instr.load_aux8) begin
        aux8_nxt = instr.aux8_val;
      end
    end
  end

  // Control state reset: PC to page 0 word 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r.page   <= PC_PAGE_RST;
      pc_r.inpage <= PC_INPAGE_RST;
      lvl_r       <= LVL_RST;
      skip_r      <= 1'b0;
      wr_r        <= 1'b0;
      cnt_r       <= 2'h0;
      cyc_r       <= 2'h1;
      busy_r      <= 1'b0;
    end else begin
      pc_r   <= pc_nxt;
      lvl_r  <= lvl_nxt;
      skip_r <= skip_nxt;
      wr_r   <= wr_nxt;
      cnt_r  <= cnt_nxt;
      cyc_r  <= cyc_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Index and aux registers carry no reset and go stale after back-up
  always_ff @(posedge clk) begin
    x_r    <= x_nxt;
    y_r    <= y_nxt;
    aux3_r <= aux3_nxt;
    aux8_r <= aux8_nxt;
  end

  // Outputs are the state registers themselves
  assign pc                   = pc_r;
  assign return_level_pointer = lvl_r;
  assign operand_ram_pointer  = {x_r, y_r};
  assign ram_wr_en            = wr_r;
  assign aux_three_bit_reg    = aux3_r;
  assign aux_eight_bit_reg    = aux8_r;
  assign skip_pending         = skip_r;
  assign busy                 = busy_r;
  assign instr_cycles         = cyc_r;
endmodule

// ---- cps_monitor.sv ----
// Port checker for the core program-state block
`timescale 1ns/1ps
module cps_monitor #(
  parameter int LAST_PAGE = 15
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire cps_pkg::cps_instr_t instr,
  input wire logic                int_entry,
  input wire cps_pkg::cps_pc_t    pc,
  input wire logic [1:0]          return_level_pointer,
  input wire logic [5:0]          operand_ram_pointer,
  input wire logic                ram_wr_en,
  input wire logic [2:0]          aux_three_bit_reg,
  input wire logic [7:0]          aux_eight_bit_reg,
  input wire logic                skip_pending,
  input wire logic                busy,
  input wire logic [1:0]          instr_cycles
);
  import cps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = instr.valid && !busy && !int_entry;
  sequence s_act; tk && !skip_pending; endsequence
  sequence s_void; tk && skip_pending; endsequence
  property p_rst; $fell(rst) |-> pc == '0; endproperty
  property p_call; s_act ##0 instr.flow == CPS_OP_CALL
    |=> return_level_pointer == $past(return_level_pointer) + 2'h1; endproperty
  property p_ret; s_act ##0 instr.flow == CPS_OP_RETURN
    |=> return_level_pointer == $past(return_level_pointer) - 2'h1; endproperty
  property p_dp; s_act ##0 instr.load_x && instr.load_y
    |=> operand_ram_pointer == {$past(instr.x_val), $past(instr.y_val)}; endproperty
  property p_wr; s_act ##0 instr.ram_wr |=> ram_wr_en; endproperty
  property p_skip; s_act ##0 instr.skip_cond |=> skip_pending; endproperty
  property p_void; s_void |=> pc.page == $past(pc.page)
    && pc.inpage == $past(pc.inpage) + 7'h01 && !ram_wr_en
    && $stable(operand_ram_pointer)
    && $stable(return_level_pointer) && !skip_pending; endproperty
  property p_short; s_void ##0 instr.flow inside {CPS_OP_TABLE_CALL, CPS_OP_RETURN,
    CPS_OP_RETURN_SKIP} |=> instr_cycles == CYC_SKIP_SHORT; endproperty
  property p_bkup; s_act ##0 instr.backup
    |=> return_level_pointer == LVL_BACKUP; endproperty
  a_rst: assert property (p_rst) else $error("reset pc");
  a_call: assert property (p_call) else $error("call level");
  a_ret: assert property (p_ret) else $error("return level");
  a_dp: assert property (p_dp) else $error("pointer");
  a_wr: assert property (p_wr) else $error("ram write");
  a_skip: assert property (p_skip) else $error("skip");
  a_void: assert property (p_void) else $error("void");
  a_short: assert property (p_short) else $error("cycles");
  a_bkup: assert property (p_bkup) else $error("backup");
endmodule
bind cps_core_state cps_monitor #(.LAST_PAGE(LAST_PAGE)) u_mon (.clk(clk), .rst(rst),
  .instr(instr), .int_entry(int_entry), .pc(pc), .return_level_pointer(return_level_pointer),
  .operand_ram_pointer(operand_ram_pointer), .ram_wr_en(ram_wr_en), .busy(busy),
  .aux_three_bit_reg(aux_three_bit_reg), .aux_eight_bit_reg(aux_eight_bit_reg),
  .skip_pending(skip_pending), .instr_cycles(instr_cycles));

// ---- cps_pkg.sv ----
// Shared constants and carriers for the core program-state block
package cps_pkg;
  localparam int PC_W        = 11;
  localparam int PAGE_W      = 4;
  localparam int INPAGE_W    = 7;
  localparam int SLOT_CNT    = 4;
  localparam int LVL_W       = 2;
  localparam int XIDX_W      = 2;
  localparam int YIDX_W      = 4;
  localparam int DPTR_W      = 6;
  localparam int AUX3_W      = 3;
  localparam int AUX8_W      = 8;
  localparam int INSTR_COUNT = 68;
  localparam logic [PAGE_W-1:0]   PC_PAGE_RST   = 4'h0;
  localparam logic [INPAGE_W-1:0] PC_INPAGE_RST = 7'h00;
  localparam logic [LVL_W-1:0]    LVL_RST       = 2'h3;
  localparam logic [LVL_W-1:0]    LVL_BACKUP    = 2'h3;
  localparam logic [1:0]          CYC_SKIP_SHORT = 2'h1;

  typedef enum logic [2:0] {
    CPS_OP_NONE,
    CPS_OP_CALL,
    CPS_OP_TABLE_CALL,
    CPS_OP_RETURN,
    CPS_OP_RETURN_SKIP
  } cps_flow_t;

  // One decoded instruction as presented by the decoder each fetch
  typedef struct packed {
    logic                  valid;
    cps_flow_t             flow;
    logic                  load_page;
    logic [PAGE_W-1:0]     page;
    logic                  load_inpage;
    logic [INPAGE_W-1:0]   inpage;
    logic                  load_x;
    logic [XIDX_W-1:0]     x_val;
    logic                  load_y;
    logic [YIDX_W-1:0]     y_val;
    logic                  load_aux3;
    logic [AUX3_W-1:0]     aux3_val;
    logic                  load_aux8;
    logic [AUX8_W-1:0]     aux8_val;
    logic                  ram_wr;
    logic                  skip_cond;
    logic [1:0]            cycles;
    logic                  backup;
  } cps_instr_t;

  typedef struct packed {
    logic [PAGE_W-1:0]   page;
    logic [INPAGE_W-1:0] inpage;
  } cps_pc_t;
endpackage

// ---- cps_ram_model.sv ----
// Data RAM array addressed by the operand pointer
`timescale 1ns/1ps
module cps_ram_model (
  input  wire logic       clk,
  input  wire logic       wr_en,
  input  wire logic [5:0] addr,
  input  wire logic [3:0] wdata,
  output logic      [3:0] rdata
);
  logic [3:0] mem [64];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end
  assign rdata = mem[addr];
endmodule

// ---- cps_return_stack.sv ----
// Four-slot return-address store addressed by the level pointer
`timescale 1ns/1ps
module cps_return_stack #(
  parameter int DEPTH = cps_pkg::SLOT_CNT,
  parameter int WIDTH = cps_pkg::PC_W
) (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);
  import cps_pkg::*;

  logic [WIDTH-1:0] return_slot_r [DEPTH];
  logic [WIDTH-1:0] return_slot_nxt [DEPTH];

  if (DEPTH != 4 || WIDTH < 1) begin : g_bad_shape
    $error("cps_return_stack: unsupported depth or width");
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      return_slot_nxt[i] = return_slot_r[i];
    end
    if (wr_en) begin
      return_slot_nxt[wr_idx] = wr_data;
    end
  end

  // Slots hold no reset value, like the real store
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      return_slot_r[i] <= return_slot_nxt[i];
    end
  end

  assign rd_data = return_slot_r[rd_idx];
endmodule

// ---- testbench.sv ----
// Self-checking bench for the core program-state block
`timescale 1ns/1ps
module testbench;
  import cps_pkg::*;
  logic clk, rst, int_entry, ram_wr_en, skip_pending, busy;
  cps_instr_t instr;
  cps_pc_t pc;
  logic [1:0] lvl, cyc;
  logic [5:0] dp;
  logic [2:0] aux3;
  logic [7:0] aux8;
  logic [3:0] wdata, rdata;
  int err_count = 0, total_checks = 0, ticks = 0;
  cps_core_state i_dut (.clk(clk), .rst(rst), .instr(instr), .int_entry(int_entry), .pc(pc),
    .return_level_pointer(lvl), .operand_ram_pointer(dp), .ram_wr_en(ram_wr_en),
    .aux_three_bit_reg(aux3), .aux_eight_bit_reg(aux8), .skip_pending(skip_pending),
    .busy(busy), .instr_cycles(cyc));
  cps_ram_model i_ram (.clk(clk), .wr_en(ram_wr_en), .addr(dp), .wdata(wdata), .rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic cps_instr_t mk(input cps_flow_t f);
    mk = '0;
    mk.valid = 1'b1;
    mk.flow = f;
    mk.cycles = 2'h1;
  endfunction
  // Present at a falling edge, hold while busy
  task automatic run(input cps_instr_t i);
    instr = i;
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
  endtask
  task automatic t_call;
    logic [10:0] ret [4];
    logic [10:0] prev;
    cps_instr_t i;
    prev = 11'h000;
    for (int k = 0; k < 4; k++) begin
      i = mk(CPS_OP_CALL);
      i.load_page = 1'b1;
      i.page = 4'(k + 1);
      i.load_inpage = 1'b1;
      i.inpage = 7'h10;
      ret[k] = prev + 11'h001;
      prev = {4'(k + 1), 7'h10};
      run(i);
      chk("pc", prev, pc);
      chk("lvl", 11'(k), 11'(lvl));
    end
    for (int k = 3; k >= 0; k--) begin
      run(mk(CPS_OP_RETURN));
      chk("ret", ret[k], pc);
    end
  endtask
  task automatic t_ptr;
    cps_instr_t i;
    i = mk(CPS_OP_NONE);
    {i.load_x, i.x_val, i.load_y, i.y_val} = {1'b1, 2'h2, 1'b1, 4'hA};
    {i.load_aux3, i.aux3_val, i.load_aux8, i.aux8_val} = {1'b1, 3'h5, 1'b1, 8'hC3};
    wdata = 4'h9;
    run(i);
    chk("dp", 11'h02A, 11'(dp));
    chk("aux", 11'h5C3, {aux3, aux8});
    i = mk(CPS_OP_NONE);
    i.ram_wr = 1'b1;
    run(i);
    run('0);
    chk("ram", 11'h009, 11'(rdata));
  endtask
  task automatic t_skip;
    cps_flow_t fl [4];
    cps_instr_t i;
    logic [10:0] p;
    fl = '{CPS_OP_TABLE_CALL, CPS_OP_RETURN, CPS_OP_RETURN_SKIP, CPS_OP_NONE};
    for (int k = 0; k < 4; k++) begin
      i = mk(CPS_OP_NONE);
      i.skip_cond = 1'b1;
      run(i);
      chk("skp", 11'h001, 11'(skip_pending));
      p = {pc.page, pc.inpage + 7'h01};
      i = mk(fl[k]);
      {i.cycles, i.load_page, i.page} = {2'h2, 1'b1, 4'hE};
      {i.load_x, i.x_val, i.ram_wr} = {1'b1, 2'h1, 1'b1};
      run(i);
      chk("vpc", p, pc);
      chk("vdp", 11'h02A, 11'(dp));
      chk("vwr", 11'h000, 11'(ram_wr_en));
      chk("cyc", (k < 3) ? 11'h001 : 11'h002, 11'(cyc));
    end
  endtask
  task automatic t_backup;
    cps_instr_t i;
    run(mk(CPS_OP_CALL));
    int_entry = 1'b1;
    run(mk(CPS_OP_NONE));
    int_entry = 1'b0;
    chk("int", 11'h001, 11'(lvl));
    i = mk(CPS_OP_NONE);
    i.backup = 1'b1;
    run(i);
    chk("bkl", 11'h003, 11'(lvl));
    chk("bkp", 11'h000, pc);
    i = mk(CPS_OP_NONE);
    {i.load_x, i.x_val, i.load_y, i.y_val} = {1'b1, 2'h1, 1'b1, 4'h7};
    run(i);
    chk("bkd", 11'h017, 11'(dp));
  endtask
  task automatic t_reset;
    cps_instr_t i;
    run(mk(CPS_OP_CALL));
    i = mk(CPS_OP_NONE);
    i.skip_cond = 1'b1;
    run(i);
    instr = '0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("rpc2", 11'h000, pc);
    chk("rlv", 11'(LVL_RST), 11'(lvl));
    chk("rsk", 11'h000, 11'(skip_pending));
    i = mk(CPS_OP_CALL);
    {i.load_inpage, i.inpage} = {1'b1, 7'h20};
    run(i);
    chk("rcl", 11'h020, pc);
    chk("rcv", 11'h000, 11'(lvl));
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    {rst, int_entry, wdata} = {1'b1, 1'b0, 4'h0};
    instr = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("rpc", 11'h000, pc);
    t_call;
    t_ptr;
    t_skip;
    t_backup;
    t_reset;
    summarize;
  end
endmodule
